// ### include/pvs_pkg.sv
/*
 * Shared constants and carrier types for the pressure valve output
 * shaping block. Assumes a 100 MHz system clock and 16-bit unsigned
 * pressure values where FULL_SCALE stands for 100 %.
 */
package pvs_pkg;

   // ************************************************************
   // Scale, clock and timing constants
   // ************************************************************
   localparam int DATA_W = 16;
   localparam logic [15:0] FULL_SCALE = 16'hffff;
   localparam int CLK_HZ = 100_000_000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_US = 1000;
   localparam logic [7:0] CLK_PER_US = 8'(NS_PER_US / CLK_PERIOD_NS);
   localparam logic [9:0] US_PER_MS = 10'h3e8;
   localparam int GAIN_SHIFT = 8;
   localparam int PWM_CNT_W = 24;

   // ************************************************************
   // Power stage limits
   // ************************************************************
   localparam logic [11:0] PWM_HZ_MIN = 12'h03d;
   localparam logic [11:0] PWM_HZ_MAX = 12'ha2c;
   localparam logic [11:0] CURRENT_MAX_MA = 12'ha28;

   // ************************************************************
   // Carrier types
   // ************************************************************
   typedef struct packed {
      logic [15:0] rampUpMs;
      logic [15:0] rampDownMs;
      logic [15:0] loopSamplePeriodUs;
      logic [15:0] kp;
      logic [15:0] ki;
      logic [15:0] kd;
      logic [15:0] kff;
      logic [15:0] maxOut;
      logic [15:0] minOffset;
      logic [15:0] trigger;
      logic [11:0] nominalMa;
      logic [11:0] pwmHz;
      logic [15:0] ditherAmp;
      logic [7:0] ditherPeriods;
   } loop_cfg_t;

   typedef struct packed {
      logic [15:0] value;
      logic enable;
   } emergency_t;

   typedef enum {MODE_RUN, MODE_FAIL} mode_t;

endpackage

// ### rtl/emergency_store.sv
/*
 * Holding store for the emergency output value and its enable.
 * Assumes the cell stands for non-volatile memory: the stored word is
 * not touched by reset, so it must be written once before first use.
 */
`timescale 1ns/1ps
module emergency_store (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic write,
   input wire pvs_pkg::emergency_t writeData,
   output pvs_pkg::emergency_t readData
);
   import pvs_pkg::*;

   emergency_t stored;

   // ************************************************************
   // Storage cell
   // ************************************************************
   // No reset here on purpose: the value survives a reset like flash
   always_ff @(posedge sys_clk) begin
      if (write) begin
         stored <= writeData;
      end
   end

   // Registered read port; reset gives a quiet output until loaded
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         readData <= '0;
      end else begin
         readData <= stored;
      end
   end

endmodule

// ### rtl/pressure_valve_output_shaping.sv
/*
 * Output shaping of a closed-loop pressure controller: command ramp,
 * PID with feed-through, MIN/MAX/TRIGGER shaping, emergency value and
 * PWM current drive. Assumes all inputs synchronous to sys_clk and
 * an outside current-loop monitor that reports an open sensor.
 */
// Overview of operation
// - On failure, drive output to the stored emergency value.
// - Reach the emergency value through the programmed ramp.
// - Emergency value is kept in a store unaffected by reset.
// - Separate rising and falling ramp times, in milliseconds.
// - Ramped command reaches a step target within its ramp time.
// - Weighted feed-through drives output from command directly.
// - Controller output is limited to a configured maximum.
// - A minimum offset is added to non-zero demands.
// - Offset applies only above trigger; below it output is zero.
// - Loop runs on a configurable sample period in microseconds.
// - PWM drive with nominal current, dither and frequency.
// - Ready only while enabled and no error is present.
// - Open current-loop sensor raises a sensor error.
// - While enabled with no open sensor the stage runs in closed-loop control.
`timescale 1ns/1ps
module pressure_valve_output_shaping (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic enable,
   input wire logic start,
   input wire logic sensorOpen,
   input wire logic [pvs_pkg::DATA_W-1:0] commandIn,
   input wire logic [pvs_pkg::DATA_W-1:0] feedbackIn,
   input wire pvs_pkg::loop_cfg_t cfg,
   input wire logic emergencyWrite,
   input wire pvs_pkg::emergency_t emergencyData,
   output logic ready,
   output logic sensorError,
   output logic sampleTick,
   output logic [pvs_pkg::DATA_W-1:0] rampedCommand,
   output logic [pvs_pkg::DATA_W-1:0] valveDemand,
   output logic pwmOut
);
   import pvs_pkg::*;

   // ************************************************************
   // Helper functions
   // ************************************************************
   // Step per sample, rounded up so the ramp never overruns its time
   function automatic logic [15:0] rampStep(input logic [15:0] ms,
                                           input logic [15:0] tsUs);
      logic [47:0] num;
      logic [47:0] den;
      logic [47:0] q;
      num = 48'(FULL_SCALE) * 48'(tsUs);
      den = 48'(ms) * 48'(US_PER_MS);
      if (den == 48'h0) q = 48'(FULL_SCALE);
      else q = (num + den - 48'h1) / den;
      if (q > 48'(FULL_SCALE)) q = 48'(FULL_SCALE);
      if (q == 48'h0) q = 48'h1;
      return q[15:0];
   endfunction

   // Saturate a signed sum into 0 .. limit
   function automatic logic [15:0] clampU(input logic signed [47:0] v,
                                         input logic [15:0] limit);
      if (v < 48'sh0) return 16'h0;
      if (v > $signed(48'(limit))) return limit;
      return v[15:0];
   endfunction

   // ************************************************************
   // Failure detection and mode
   // ************************************************************
   mode_t mode;
   emergency_t emergency;
   logic failure;
   logic [15:0] emergencyTarget;

   emergency_store u_store (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .write(emergencyWrite),
      .writeData(emergencyData),
      .readData(emergency)
   );

   assign failure = sensorOpen | ~enable;
   assign ready = (mode == MODE_RUN);
   assign emergencyTarget = emergency.enable ? emergency.value
                                             : 16'h0;

   // Mode and sensor error follow the inputs one cycle late
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mode <= MODE_FAIL;
         sensorError <= 1'b0;
      end else begin
         sensorError <= sensorOpen;
         mode <= failure ? MODE_FAIL : MODE_RUN;
      end
   end

   // ************************************************************
   // Sample period timer
   // ************************************************************
   logic [7:0] usPre;
   logic [15:0] usCnt;
   logic [15:0] periodUs;

   assign periodUs = (cfg.loopSamplePeriodUs == 16'h0)
                     ? 16'h1 : cfg.loopSamplePeriodUs;

   // Microsecond prescaler, then a count of the sample period
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         usPre <= 8'h0;
         usCnt <= 16'h0;
         sampleTick <= 1'b0;
      end else begin
         sampleTick <= 1'b0;
         if (usPre == CLK_PER_US - 8'h1) begin
            usPre <= 8'h0;
            if (usCnt >= periodUs - 16'h1) begin
               usCnt <= 16'h0;
               sampleTick <= 1'b1;
            end else begin
               usCnt <= usCnt + 16'h1;
            end
         end else begin
            usPre <= usPre + 8'h1;
         end
      end
   end

   // ************************************************************
   // Command ramp
   // ************************************************************
   logic [15:0] rampTarget;
   logic [15:0] stepUp;
   logic [15:0] stepDown;

   assign rampTarget = (mode == MODE_FAIL) ? emergencyTarget
                     : (start ? commandIn : 16'h0);
   assign stepUp = rampStep(cfg.rampUpMs, periodUs);
   assign stepDown = rampStep(cfg.rampDownMs, periodUs);

   // Move toward target each sample without overshooting it
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rampedCommand <= 16'h0;
      end else if (sampleTick) begin
         if (rampTarget > rampedCommand) begin
            if (rampTarget - rampedCommand <= stepUp)
               rampedCommand <= rampTarget;
            else
               rampedCommand <= rampedCommand + stepUp;
         end else if (rampTarget < rampedCommand) begin
            if (rampedCommand - rampTarget <= stepDown)
               rampedCommand <= rampTarget;
            else
               rampedCommand <= rampedCommand - stepDown;
         end
      end
   end

   // ************************************************************
   // PID with feed-through
   // ************************************************************
   logic signed [16:0] err;
   logic signed [16:0] prevErr;
   logic signed [47:0] integ;
   logic signed [47:0] next_integ;
   logic signed [47:0] pidSum;
   logic [15:0] loopOut;
   logic [15:0] shaped;

   assign err = $signed({1'b0, rampedCommand})
              - $signed({1'b0, feedbackIn});

   // Integrator clamps to full scale so it cannot wind up forever
   always_comb begin
      next_integ = integ + ((48'(err) * $signed(48'({1'b0, cfg.ki})))
                   >>> GAIN_SHIFT);
      if (next_integ > $signed(48'(FULL_SCALE)))
         next_integ = 48'(FULL_SCALE);
      if (next_integ < -$signed(48'(FULL_SCALE)))
         next_integ = -$signed(48'(FULL_SCALE));
      pidSum = ((48'(err) * $signed(48'({1'b0, cfg.kp}))
               + 48'(err - prevErr) * $signed(48'({1'b0, cfg.kd}))
               + $signed(48'({1'b0, rampedCommand}))
                 * $signed(48'({1'b0, cfg.kff})))
               >>> GAIN_SHIFT) + integ;
      loopOut = clampU(pidSum, cfg.maxOut);
   end

   // Loop state only advances while closed-loop control is allowed
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         integ <= '0;
         prevErr <= '0;
      end else if (mode == MODE_FAIL) begin
         integ <= '0;
         prevErr <= '0;
      end else if (sampleTick) begin
         integ <= next_integ;
         prevErr <= err;
      end
   end

   // ************************************************************
   // MIN / MAX / TRIGGER shaping
   // ************************************************************
   // Emergency drive bypasses the dead band: it is a chosen opening
   always_comb begin
      if (mode == MODE_FAIL)
         shaped = rampedCommand;
      else if (loopOut == 16'h0 || loopOut <= cfg.trigger)
         shaped = 16'h0;
      else
         shaped = clampU(48'(loopOut) + 48'(cfg.minOffset),
                         cfg.maxOut);
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         valveDemand <= 16'h0;
      end else if (sampleTick) begin
         valveDemand <= shaped;
      end
   end

   // ************************************************************
   // PWM current drive with dither
   // ************************************************************
   logic [PWM_CNT_W-1:0] pwmCnt;
   logic [PWM_CNT_W-1:0] pwmPeriod;
   logic [PWM_CNT_W-1:0] pwmDuty;
   logic [11:0] hzClamped;
   logic [11:0] maClamped;
   logic [7:0] ditherCnt;
   logic ditherHigh;
   logic [15:0] dithered;
   logic [47:0] dutyCalc;

   assign hzClamped = (cfg.pwmHz < PWM_HZ_MIN) ? PWM_HZ_MIN
                    : (cfg.pwmHz > PWM_HZ_MAX) ? PWM_HZ_MAX
                    : cfg.pwmHz;
   assign maClamped = (cfg.nominalMa > CURRENT_MAX_MA) ? CURRENT_MAX_MA
                    : cfg.nominalMa;

   // Dither only on a live demand, so zero stays a true zero
   always_comb begin
      if (valveDemand == 16'h0)
         dithered = 16'h0;
      else if (ditherHigh)
         dithered = clampU(48'(valveDemand) + 48'(cfg.ditherAmp),
                           FULL_SCALE);
      else
         dithered = clampU(48'(valveDemand) - 48'(cfg.ditherAmp),
                           FULL_SCALE);
      dutyCalc = 48'(pwmPeriod) * 48'(dithered) * 48'(maClamped)
               / (48'(FULL_SCALE) * 48'(CURRENT_MAX_MA));
   end

   // Period and duty are taken at the start of each PWM period only
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pwmCnt <= '0;
         pwmPeriod <= PWM_CNT_W'(CLK_HZ / int'(PWM_HZ_MAX));
         pwmDuty <= '0;
         ditherCnt <= 8'h0;
         ditherHigh <= 1'b0;
         pwmOut <= 1'b0;
      end else begin
         if (pwmCnt >= pwmPeriod - PWM_CNT_W'(1)) begin
            pwmCnt <= '0;
            pwmPeriod <= PWM_CNT_W'(CLK_HZ / int'(hzClamped));
            pwmDuty <= dutyCalc[PWM_CNT_W-1:0];
            if (ditherCnt >= cfg.ditherPeriods) begin
               ditherCnt <= 8'h0;
               ditherHigh <= ~ditherHigh;
            end else begin
               ditherCnt <= ditherCnt + 8'h1;
            end
         end else begin
            pwmCnt <= pwmCnt + PWM_CNT_W'(1);
         end
         pwmOut <= (pwmCnt < pwmDuty);
      end
   end

endmodule

// ### tb/pressure_valve_output_shaping_tb.sv
/* Bench: ramp, shaping and failure compared with an integer model.
   Assumes pvs_pkg, the design and the tb modules compiled first. */
`timescale 1ns/1ps
module pressure_valve_output_shaping_tb;
   import pvs_pkg::*;
   // ************************************************
   // Stimulus, model state and instances
   // ************************************************
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic enable = 1'b1;
   logic start = 1'b0;
   logic wireBroken = 1'b0;
   logic emergencyWrite = 1'b0;
   logic [15:0] commandIn = 16'h0000;
   emergency_t emergencyData = '0;
   loop_cfg_t cfg;
   logic sensorOpen, ready, sensorError, sampleTick, pwmOut;
   logic [15:0] feedbackIn, rampedCommand, valveDemand;
   int pwmHigh, miscompares, compares, ramp, emVal, emOn, up, dn;
   integer seed;
   always #5 sys_clk = ~sys_clk;
   pressure_valve_output_shaping pressure_valve_output_shaping_i (
      .sys_clk(sys_clk), .nrst(nrst), .enable(enable), .start(start),
      .sensorOpen(sensorOpen), .commandIn(commandIn),
      .feedbackIn(feedbackIn), .cfg(cfg),
      .emergencyWrite(emergencyWrite), .emergencyData(emergencyData),
      .ready(ready), .sensorError(sensorError), .sampleTick(sampleTick),
      .rampedCommand(rampedCommand), .valveDemand(valveDemand),
      .pwmOut(pwmOut));
   valve_sensor_model valve_sensor_model_i (
      .sys_clk(sys_clk), .nrst(nrst), .valveDemand(valveDemand),
      .pwmOut(pwmOut), .wireBroken(wireBroken), .feedbackIn(feedbackIn),
      .sensorOpen(sensorOpen), .pwmHigh(pwmHigh));
   // ************************************************
   // Tasks and model
   // ************************************************
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Gain of one on the feed-through, so the loop output is the ramp
   function automatic int shape(int r);
      int o;
      o = (r > cfg.maxOut) ? cfg.maxOut : r;
      if (o == 0 || o <= cfg.trigger) return 0;
      o = o + cfg.minOffset;
      return (o > cfg.maxOut) ? cfg.maxOut : o;
   endfunction
   // One sample: wait for the tick, step the model, compare
   task automatic sample(int n);
      int w, pre, t;
      for (int i = 0; i < n; i++) begin
         w = 0;
         do begin
            @(negedge sys_clk);
            w++;
         end while (sampleTick !== 1'b1 && w < 1000);
         if (w >= 1000) begin
            miscompares++;
            print_verdict();
         end
         pre = ramp;
         if (!enable || wireBroken) t = emOn ? emVal : 0;
         else t = start ? commandIn : 0;
         if (t > ramp) ramp = (ramp + up > t) ? t : ramp + up;
         else ramp = (ramp - dn < t) ? t : ramp - dn;
         @(negedge sys_clk);
         check("ramp", rampedCommand, 16'(ramp));
         check("ready", 16'(ready), 16'(enable && !wireBroken));
         if (enable && !wireBroken)
            check("demand", valveDemand, 16'(shape(pre)));
         else
            check("fail demand", valveDemand, 16'(pre));
      end
   endtask
   task automatic doReset();
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (16) @(posedge sys_clk);
      check("reset ready", 16'(ready), 16'h0000);
      check("reset demand", valveDemand, 16'h0000);
      nrst <= 1'b1;
      ramp = 0;
   endtask
   task automatic writeEm(logic [15:0] v, logic en);
      @(posedge sys_clk);
      emergencyData <= '{value: v, enable: en};
      emergencyWrite <= 1'b1;
      @(posedge sys_clk);
      emergencyWrite <= 1'b0;
      emVal = v;
      emOn = en;
   endtask
   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      seed = 32'hf0d0;
      cfg = '0;
      cfg.rampUpMs = 16'h0001;
      cfg.rampDownMs = 16'h0002;
      cfg.loopSamplePeriodUs = 16'h0002;
      cfg.kff = 16'h0100;
      cfg.maxOut = 16'h0800;
      cfg.minOffset = 16'h0200;
      cfg.trigger = 16'h0100;
      cfg.nominalMa = 12'ha28;
      cfg.pwmHz = 12'hfff;
      up = (65535 * 2 + 999) / 1000;
      dn = (65535 * 2 + 1999) / 2000;
      doReset();
      writeEm(16'h0400, 1'b1);
      @(posedge sys_clk);
      start <= 1'b1;
      // Random commands: steps in both directions, some in dead band
      for (int i = 0; i < 5; i++) begin
         @(posedge sys_clk);
         commandIn <= 16'($random(seed)) & 16'h0fff;
         sample(6);
      end
      // Start low: the ramp must fall back toward zero
      @(posedge sys_clk);
      start <= 1'b0;
      sample(3);
      @(posedge sys_clk);
      start <= 1'b1;
      commandIn <= 16'h0600;
      // Over-range frequency setting still gives a drive
      for (int i = 0; i < 400 && pwmHigh == 0; i++) sample(1);
      check("pwm", 16'(pwmHigh > 0), 16'h0001);
      // Stored value survives a reset
      doReset();
      @(posedge sys_clk);
      enable <= 1'b0;
      sample(12);
      writeEm(16'h0400, 1'b0);
      @(posedge sys_clk);
      enable <= 1'b1;
      wireBroken <= 1'b1;
      repeat (2) @(negedge sys_clk);
      check("sensor error", 16'(sensorError), 16'h0001);
      sample(18);
      print_verdict();
   end
endmodule

// ### tb/pvs_properties.sv
/* Port checker for the output shaping block.
   Assumes cfg is held static and one clock domain. */
`timescale 1ns/1ps
module pvs_properties (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic enable,
   input wire logic sensorOpen,
   input wire pvs_pkg::loop_cfg_t cfg,
   input wire logic ready,
   input wire logic sensorError,
   input wire logic sampleTick,
   input wire logic [pvs_pkg::DATA_W-1:0] rampedCommand,
   input wire logic [pvs_pkg::DATA_W-1:0] valveDemand
);
   import pvs_pkg::*;
   // ************************************************
   // Helpers and properties
   // ************************************************
   int gap;
   int upStep;
   int dnStep;
   logic seen;
   // Largest ramp step per sample, rounded up
   assign upStep = (65535 * cfg.loopSamplePeriodUs + cfg.rampUpMs * 1000
      - 1) / (cfg.rampUpMs * 1000);
   assign dnStep = (65535 * cfg.loopSamplePeriodUs + cfg.rampDownMs * 1000
      - 1) / (cfg.rampDownMs * 1000);
   // Cycles since last tick; the first tick has no reference
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         gap <= 0;
         seen <= 1'b0;
      end else if (sampleTick) begin
         gap <= 0;
         seen <= 1'b1;
      end else begin
         gap <= gap + 1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   chk_ready_level: assert property (
      $past(nrst) |-> ready == $past(enable && !sensorOpen))
      else $error("ready does not follow enable and sensor");
   chk_sensor_flag: assert property (
      $past(nrst) |-> sensorError == $past(sensorOpen))
      else $error("sensor error does not follow open loop");
   chk_tick_period: assert property (
      sampleTick && seen |-> gap == cfg.loopSamplePeriodUs * CLK_PER_US - 1)
      else $error("sample period wrong");
   chk_tick_pulse: assert property (
      sampleTick |=> !sampleTick)
      else $error("tick longer than one cycle");
   chk_ramp_hold: assert property (
      !sampleTick |=> $stable(rampedCommand))
      else $error("ramp moved between ticks");
   chk_demand_hold: assert property (
      !sampleTick |=> $stable(valveDemand))
      else $error("demand moved between ticks");
   chk_ramp_step: assert property (
      sampleTick |=> (rampedCommand >= $past(rampedCommand)) ?
      (rampedCommand - $past(rampedCommand) <= upStep) :
      ($past(rampedCommand) - rampedCommand <= dnStep))
      else $error("ramp step too large");
   chk_max_limit: assert property (
      sampleTick && ready |=> valveDemand <= cfg.maxOut)
      else $error("demand above maximum");
   chk_dead_band: assert property (
      sampleTick && ready |=> valveDemand == 0 || valveDemand > cfg.trigger)
      else $error("demand inside dead band");
   chk_fail_demand: assert property (
      sampleTick && !ready |=> valveDemand == $past(rampedCommand))
      else $error("failure demand not the ramp");
endmodule
bind pressure_valve_output_shaping pvs_properties pvs_properties_i (
   .sys_clk(sys_clk), .nrst(nrst), .enable(enable),
   .sensorOpen(sensorOpen), .cfg(cfg), .ready(ready),
   .sensorError(sensorError), .sampleTick(sampleTick),
   .rampedCommand(rampedCommand), .valveDemand(valveDemand));

// ### tb/valve_sensor_model.sv
/* Valve and pressure sensor seen from the block's pins.
   Assumes pressure creeps toward demand by one count a cycle. */
`timescale 1ns/1ps
module valve_sensor_model (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [pvs_pkg::DATA_W-1:0] valveDemand,
   input wire logic pwmOut,
   input wire logic wireBroken,
   output logic [pvs_pkg::DATA_W-1:0] feedbackIn,
   output logic sensorOpen,
   output int pwmHigh
);
   // ************************************************
   // Plant
   // ************************************************
   logic [15:0] pressure;
   // Open loop shows a toggling line, never a stale value
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pressure <= 16'h0000;
         feedbackIn <= 16'h0000;
         pwmHigh <= 0;
      end else begin
         if (pressure < valveDemand) pressure <= pressure + 16'h0001;
         if (pressure > valveDemand) pressure <= pressure - 16'h0001;
         feedbackIn <= wireBroken ? ~feedbackIn : pressure;
         if (pwmOut) pwmHigh <= pwmHigh + 1;
      end
   end
   assign sensorOpen = wireBroken;
endmodule
